/* srpc_pkg.sv */
// package for the sdram refresh and power command block
package srpc_pkg;
    localparam int ROW_W = 12;
    localparam int ROW_COUNT = 4096;
    localparam logic [2:0] CL_TWO = 3'h2;
    localparam logic [2:0] CL_THREE = 3'h3;
    localparam int MASK_RD_LAT = 2;
    localparam real SREF_TIME_MS = 64.0;
    localparam real CLK_PERIOD_NS = 5.0;
    localparam int REFRESH_ROWS = 4096;
    typedef enum logic [2:0] {
        SRPC_CMD_DESELECT,
        SRPC_CMD_NOP,
        SRPC_CMD_BURST_STOP,
        SRPC_CMD_REFRESH,
        SRPC_CMD_SELF_ENTRY,
        SRPC_CMD_OTHER
    } srpc_cmd_type;
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } srpc_pins_type;
    typedef struct packed {
        logic active;
        logic is_read;
        logic auto_pre;
    } srpc_burst_type;
endpackage : srpc_pkg

/* srpc_decode.sv */
// command decoder for the refresh and power command block
`timescale 1ns/1ps
`default_nettype none
module srpc_decode (
    input wire srpc_pkg::srpc_pins_type pins_i,
    input wire logic cke_i,
    output srpc_pkg::srpc_cmd_type cmd_o
);
    always_comb begin
        if (pins_i.cs_n) begin
            cmd_o = srpc_pkg::SRPC_CMD_DESELECT;
        end else begin
            unique case ({pins_i.ras_n, pins_i.cas_n, pins_i.we_n})
                3'b111: cmd_o = srpc_pkg::SRPC_CMD_NOP;
                3'b110: cmd_o = srpc_pkg::SRPC_CMD_BURST_STOP;
                3'b001: cmd_o = cke_i ? srpc_pkg::SRPC_CMD_REFRESH : srpc_pkg::SRPC_CMD_SELF_ENTRY;
                default: cmd_o = srpc_pkg::SRPC_CMD_OTHER;
            endcase
        end
    end
endmodule : srpc_decode
`default_nettype wire

/* srpc_top.sv */
// refresh, burst stop, power state and data mask handling of the sdram
`timescale 1ns/1ps
`default_nettype none
module srpc_top #(
    parameter int ROW_W = srpc_pkg::ROW_W
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire srpc_pkg::srpc_pins_type pins_i,
    input wire logic cke_i,
    input wire logic dqm_i,
    input wire logic [2:0] cas_latency_i,
    input wire logic burst_start_i,
    input wire logic burst_is_read_i,
    input wire logic burst_auto_pre_i,
    input wire logic burst_done_i,
    output logic refresh_o,
    output logic [ROW_W-1:0] refresh_row_o,
    output logic self_refresh_o,
    output logic power_down_o,
    output logic clk_suspend_o,
    output logic burst_active_o,
    output logic read_data_valid_o,
    output logic write_enable_o,
    output logic buffers_on_o,
    output logic read_oe_o
);
    srpc_pkg::srpc_cmd_type cmd;
    srpc_pkg::srpc_burst_type burst_r;
    logic [ROW_W-1:0] row_r;
    logic refresh_r;
    logic self_r;
    logic pd_r;
    logic susp_r;
    logic [2:0] drain_r;
    logic [srpc_pkg::MASK_RD_LAT-1:0] mask_pipe_r;
    logic int_clk_en;
    logic cmd_live;

    // a burst or a read drain still occupies the data path
    function automatic logic path_busy(input srpc_pkg::srpc_burst_type burst, input logic [2:0] drain);
        return burst.active || drain != 3'h0;
    endfunction : path_busy

    srpc_decode u_decode (
        .pins_i(pins_i),
        .cke_i(cke_i),
        .cmd_o(cmd)
    );

    // internal clock runs unless suspended, powered down or in self refresh
    assign int_clk_en = !susp_r && !pd_r && !self_r;
    assign cmd_live = int_clk_en && cke_i;

    // burst tracking and termination
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            burst_r <= '0;
            drain_r <= 3'h0;
        end else if (cmd_live) begin
            if (burst_start_i) begin
                burst_r <= '{active: 1'b1, is_read: burst_is_read_i, auto_pre: burst_auto_pre_i};
                drain_r <= 3'h0;
            end else if (cmd == srpc_pkg::SRPC_CMD_BURST_STOP && burst_r.active && !burst_r.auto_pre) begin
                burst_r.active <= 1'b0;
                drain_r <= burst_r.is_read ? cas_latency_i : 3'h0;
            end else if (burst_done_i) begin
                burst_r.active <= 1'b0;
            end else if (drain_r != 3'h0) begin
                drain_r <= drain_r - 3'h1;
            end
        end
    end

    // auto refresh with internal row counter
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            row_r <= '0;
            refresh_r <= 1'b0;
        end else begin
            refresh_r <= 1'b0;
            if (cmd_live && cmd == srpc_pkg::SRPC_CMD_REFRESH) begin
                refresh_r <= 1'b1;
                row_r <= row_r + 1'b1;
            end
        end
    end

    // self refresh entry and exit
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            self_r <= 1'b0;
        end else if (self_r) begin
            if (cke_i) begin
                self_r <= 1'b0;
            end
        end else if (int_clk_en && cmd == srpc_pkg::SRPC_CMD_SELF_ENTRY && !burst_r.active) begin
            self_r <= 1'b1;
        end
    end

    // clock suspend and power-down
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            susp_r <= 1'b0;
            pd_r <= 1'b0;
        end else if (susp_r || pd_r) begin
            if (cke_i) begin
                susp_r <= 1'b0;
                pd_r <= 1'b0;
            end
        end else if (!self_r && !cke_i && cmd != srpc_pkg::SRPC_CMD_SELF_ENTRY) begin
            susp_r <= path_busy(burst_r, drain_r);
            pd_r <= !path_busy(burst_r, drain_r);
        end
    end

    // data mask: read output disable delayed two cycles
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            mask_pipe_r <= '0;
        end else begin
            mask_pipe_r <= {mask_pipe_r[srpc_pkg::MASK_RD_LAT-2:0], dqm_i};
        end
    end

    assign refresh_o = refresh_r;
    assign refresh_row_o = row_r;
    assign self_refresh_o = self_r;
    assign power_down_o = pd_r;
    assign clk_suspend_o = susp_r;
    assign burst_active_o = burst_r.active;
    assign read_data_valid_o = int_clk_en && ((burst_r.active && burst_r.is_read) || drain_r != 3'h0);
    assign write_enable_o = int_clk_en && cke_i && burst_r.active && !burst_r.is_read && !dqm_i;
    assign buffers_on_o = !pd_r && !self_r;
    assign read_oe_o = read_data_valid_o && !mask_pipe_r[srpc_pkg::MASK_RD_LAT-1];

    // steps of refresh, read drain and masked clock
    sequence s_refresh_taken;
        cmd_live && cmd == srpc_pkg::SRPC_CMD_REFRESH;
    endsequence
    sequence s_read_stop;
        cmd_live && !burst_start_i && cmd == srpc_pkg::SRPC_CMD_BURST_STOP && burst_r.active && burst_r.is_read
            && !burst_r.auto_pre;
    endsequence
    sequence s_drain_step;
        cmd_live && !burst_start_i && !burst_done_i && !burst_r.active && drain_r != 3'h0;
    endsequence
    sequence s_clock_masked;
        !int_clk_en;
    endsequence

    AST_NOP_HOLDS: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (cmd == srpc_pkg::SRPC_CMD_NOP) |=> !refresh_o) else $error("nop caused refresh");
    AST_DESEL: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        pins_i.cs_n |=> !refresh_o) else $error("deselect caused refresh");
    AST_STOP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (cmd_live && !burst_start_i && cmd == srpc_pkg::SRPC_CMD_BURST_STOP && burst_r.active && !burst_r.auto_pre)
        |=> !burst_active_o) else $error("burst not stopped");
    AST_AUTOPRE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (cmd_live && !burst_start_i && !burst_done_i && cmd == srpc_pkg::SRPC_CMD_BURST_STOP && burst_r.auto_pre
        && burst_r.active) |=> burst_active_o) else $error("auto precharge burst stopped");
    AST_DRAIN: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_read_stop |=> (drain_r == $past(cas_latency_i))) else $error("drain count wrong");
    AST_ROW: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        refresh_o |-> (refresh_row_o == $past(refresh_row_o) + 1'b1)) else $error("row not advanced");
    AST_SELF: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        self_refresh_o && !cke_i |=> self_refresh_o) else $error("self refresh left early");
    AST_SUSP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        clk_suspend_o |-> $stable(burst_r)) else $error("state changed in suspend");
    AST_PD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        power_down_o |-> !buffers_on_o) else $error("buffers on in power-down");
    AST_WAKE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (power_down_o && cke_i) |=> !power_down_o) else $error("no power-down exit");
    AST_MASK: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        dqm_i |-> ##2 !read_oe_o) else $error("read output not disabled");

    AST_REFRESH: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_refresh_taken |=> refresh_o) else $error("refresh not taken");
    AST_DRAIN_STEP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_drain_step |=> (drain_r == $past(drain_r) - 3'h1)) else $error("drain not counting down");
    AST_DRAIN_LIVE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (s_read_stop ##0 (cas_latency_i != 3'h0)) |=> read_data_valid_o) else $error("read data cut at stop");
    AST_CLOCK_MASKED: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_clock_masked |=> !refresh_o && $stable(refresh_row_o)) else $error("refresh while clock masked");
    AST_SELF_EXIT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (self_refresh_o && cke_i) |=> !self_refresh_o && buffers_on_o) else $error("no self refresh exit");
    AST_SUSP_WAKE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (clk_suspend_o && cke_i) |=> !clk_suspend_o) else $error("no clock suspend exit");
    AST_WMASK: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        dqm_i |-> !write_enable_o) else $error("masked write word stored");
    AST_PD_ENTRY: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (int_clk_en && !cke_i && cmd != srpc_pkg::SRPC_CMD_SELF_ENTRY && !path_busy(burst_r, drain_r))
        |=> power_down_o) else $error("power-down not entered");
    AST_SUSP_ENTRY: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (int_clk_en && !cke_i && cmd != srpc_pkg::SRPC_CMD_SELF_ENTRY && path_busy(burst_r, drain_r))
        |=> clk_suspend_o) else $error("clock suspend not entered");
endmodule : srpc_top
`default_nettype wire

/* srpc_ctrl_model.sv */
// memory controller model driving command pins and clock enable
`timescale 1ns/1ps
`default_nettype none
module srpc_ctrl_model (
    input wire logic ref_clk_i,
    output srpc_pkg::srpc_pins_type pins_o,
    output logic cke_o
);
    // nops after each refresh so a full row cycle passes before the next command
    localparam int RC_NOPS = 10;
    initial begin
        pins_o = 4'hF;
        cke_o = 1'b1;
    end
    // one command, held over one rising edge, changed just after it
    task automatic send(input logic [3:0] cmd, input logic cke);
        pins_o = cmd;
        cke_o = cke;
        @(posedge ref_clk_i);
        #1;
    endtask : send
    // no-operation cycles keep the present clock enable level
    task automatic idle(input int n);
        repeat (n) send(4'h7, cke_o);
    endtask : idle
    // back-to-back auto refreshes, each spaced by the row cycle time
    task automatic refresh_run(input int n);
        repeat (n) begin
            send(4'h1, 1'b1);
            idle(RC_NOPS);
        end
    endtask : refresh_run
endmodule : srpc_ctrl_model
`default_nettype wire

/* tb_top.sv */
// self-checking testbench for the refresh and power command block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int CYCLE_LIMIT = 50000;
    logic ref_clk_i;
    logic rst_i;
    srpc_pkg::srpc_pins_type pins;
    logic cke;
    logic dqm;
    logic bst;
    logic brd;
    logic bap;
    logic bdone;
    logic [2:0] cl;
    logic refresh, self_ref, pdown, susp, bact, rvalid, wen, bufon, roe;
    logic [srpc_pkg::ROW_W-1:0] row;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    srpc_ctrl_model ctl_inst (.ref_clk_i(ref_clk_i), .pins_o(pins), .cke_o(cke));
    srpc_top srpc_top_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .pins_i(pins), .cke_i(cke), .dqm_i(dqm),
        .cas_latency_i(cl), .burst_start_i(bst), .burst_is_read_i(brd), .burst_auto_pre_i(bap),
        .burst_done_i(bdone), .refresh_o(refresh), .refresh_row_o(row), .self_refresh_o(self_ref),
        .power_down_o(pdown), .clk_suspend_o(susp), .burst_active_o(bact), .read_data_valid_o(rvalid),
        .write_enable_o(wen), .buffers_on_o(bufon), .read_oe_o(roe));
    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == CYCLE_LIMIT) begin
            mismatches++;
            finish_test();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check
    task automatic start(input logic rd, input logic ap, input logic mask);
        bst = 1'b1;
        brd = rd;
        bap = ap;
        dqm = mask;
        ctl_inst.idle(1);
        bst = 1'b0;
    endtask : start
    task automatic end_burst();
        bdone = 1'b1;
        ctl_inst.idle(1);
        bdone = 1'b0;
        check(bact, 1'b0);
    endtask : end_burst
    task automatic t_refresh();
        ctl_inst.send(4'h1, 1'b1);
        check({refresh, row}, {1'b1, 12'h001});
        ctl_inst.idle(1);
        check(refresh, 1'b0);
        ctl_inst.idle(11);
        ctl_inst.send(4'h1, 1'b1);
        check(row, 12'h002);
        ctl_inst.idle(12);
        ctl_inst.send(4'h9, 1'b1);
        check(refresh, 1'b0);
        ctl_inst.send(4'h7, 1'b1);
        check({refresh, row}, {1'b0, 12'h002});
    endtask : t_refresh
    task automatic t_stop(input logic ap, input logic [2:0] lat);
        cl = lat;
        start(1'b1, ap, 1'b0);
        ctl_inst.send(4'h6, 1'b1);
        check({bact, rvalid}, {ap, 1'b1});
        if (!ap) begin
            ctl_inst.idle(lat - 1);
            check(rvalid, 1'b1);
            ctl_inst.idle(1);
            check(rvalid, 1'b0);
        end else begin
            end_burst();
        end
    endtask : t_stop
    task automatic t_suspend();
        start(1'b1, 1'b0, 1'b0);
        ctl_inst.send(4'h7, 1'b0);
        check({susp, pdown, bact}, 3'h5);
        ctl_inst.idle(3);
        check({susp, bact}, 2'h3);
        ctl_inst.send(4'h7, 1'b1);
        check(susp, 1'b0);
        end_burst();
    endtask : t_suspend
    task automatic t_power();
        ctl_inst.send(4'h7, 1'b0);
        check({pdown, bufon, susp}, 3'h4);
        ctl_inst.send(4'h7, 1'b1);
        check({pdown, bufon}, 2'h1);
        ctl_inst.idle(1);
        ctl_inst.refresh_run(srpc_pkg::REFRESH_ROWS);
        check(row, 12'h002);
        ctl_inst.send(4'h1, 1'b0);
        check({self_ref, bufon, refresh}, 3'h4);
        ctl_inst.send(4'h6, 1'b0);
        ctl_inst.idle(4);
        check({self_ref, bact}, 2'h2);
        ctl_inst.send(4'h7, 1'b1);
        check({self_ref, bufon}, 2'h1);
        ctl_inst.idle(12);
    endtask : t_power
    task automatic t_mask();
        start(1'b0, 1'b0, 1'b1);
        check(wen, 1'b0);
        dqm = 1'b0;
        ctl_inst.idle(1);
        check(wen, 1'b1);
        end_burst();
        start(1'b1, 1'b0, 1'b0);
        dqm = 1'b1;
        ctl_inst.idle(1);
        check(roe, 1'b1);
        ctl_inst.idle(1);
        check(roe, 1'b0);
        dqm = 1'b0;
        end_burst();
    endtask : t_mask
    task automatic finish_test();
        $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test
    initial begin
        rst_i = 1'b1;
        dqm = 1'b0;
        bst = 1'b0;
        brd = 1'b0;
        bap = 1'b0;
        bdone = 1'b0;
        cl = srpc_pkg::CL_THREE;
        repeat (12) @(posedge ref_clk_i);
        #1 rst_i = 1'b0;
        check({refresh, self_ref, pdown, susp, bact, bufon, row}, {6'h01, 12'h000});
        t_refresh();
        t_stop(1'b0, srpc_pkg::CL_TWO);
        t_stop(1'b0, srpc_pkg::CL_THREE);
        t_stop(1'b1, srpc_pkg::CL_THREE);
        t_suspend();
        t_power();
        t_mask();
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
